// [rtl/lac_ctrl.sv]
// Purpose : link aggregation control for one aggregate of several ports
// Assumes : management writes config as plain levels; pdu_rx is one cycle
// Notes   : the aggregate key is the aggregate id, shared by all ports
//           timers count whole ticks, so an expiry may land up to one tick early
//           a port is dynamic only with member set and an active or passive mode
//
// How it works
// RULE_01 - aggregate is down when fewer members are up than the minimum
// RULE_02 - minimum members accepts 1 to 32 and resets to 1
// RULE_03 - active ports transmit pdus on their own
// RULE_04 - passive ports transmit only after hearing the partner
// RULE_05 - system id is system priority joined with switch mac
// RULE_06 - system priority 1 to 65535, resets to 32768, larger is lower
// RULE_07 - port priority 1 to 65535, default and cleared value 32768
// RULE_08 - short timeout sends every second and expires after 3 seconds
// RULE_09 - long timeout (default) sends every 30 s, expires after 90 s
// RULE_10 - pdus on ports without lacp configuration are dropped
// RULE_11 - forwarding enabled floods the pdu on its vlan
// RULE_12 - on a bridge domain delimiter vlan the pdu floods the domain
// RULE_13 - forwarding only on physical ports and static aggregates
// RULE_14 - forwarding on a static aggregate applies to every member
// RULE_15 - lacp enabled ports trap pdus to the cpu
// RULE_16 - forced activation brings a link up without partner pdus
// RULE_17 - forced activation only accepted on dynamic members
// RULE_18 - ports attach when they join and detach when they leave
// RULE_19 - control enables and disables collection and distribution
// RULE_20 - one conversation always maps to one member link
// RULE_21 - administrative key equals aggregate id; only equal keys aggregate
// RULE_22 - static members exchange no pdus, follow link and admin state
// RULE_23 - tx and expiry timers run from a common one second tick
// RULE_24 - partner expiry flags an event and drops the port from the set
`timescale 1ns/1ps
`default_nettype none
`include "lac_cfg.svh"

module lac_ctrl #(
  parameter int          NPORT    = 4,
  parameter int          TICK_CYC = `LAC_TICK_CYC,
  parameter logic [15:0] AGG_ID   = 16'h001E
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire lac_pkg::lac_port_cfg_t      port_cfg [NPORT],
  input  wire logic [NPORT-1:0]            link_up,
  input  wire logic [NPORT-1:0]            pdu_rx,
  input  wire logic [15:0]                 pdu_rx_key [NPORT],
  input  wire logic [NPORT-1:0]            rx_vlan_bd,
  input  wire logic                        agg_static,
  input  wire logic                        agg_fwd_en,
  input  wire logic [5:0]                  min_links_wr,
  input  wire logic                        min_links_we,
  input  wire logic [15:0]                 sys_prio_wr,
  input  wire logic                        sys_prio_we,
  input  wire logic                        sys_prio_clr,
  input  wire logic [47:0]                 sw_mac,
  input  wire logic [15:0]                 conv_hash,
  output logic                             agg_oper_up,
  output logic [63:0]                      sys_id,
  output logic [15:0]                      admin_key,
  output logic [5:0]                       min_links,
  output logic [15:0]                      port_prio [NPORT],
  output logic [NPORT-1:0]                 pdu_tx,
  output lac_pkg::lac_pdu_act_t            pdu_act [NPORT],
  output logic [NPORT-1:0]                 attached,
  output logic [NPORT-1:0]                 collecting,
  output logic [NPORT-1:0]                 distributing,
  output logic [NPORT-1:0]                 expired_evt,
  output logic [NPORT-1:0]                 cfg_reject,
  output logic [$clog2(NPORT)-1:0]         conv_port,
  output logic                             conv_valid
);

  // ---------------------------------------------------------------
  // shared one second tick
  // ---------------------------------------------------------------
  logic [31:0] tick_cnt_r;
  logic        tick_r;

  // a single tick for all ports keeps timers in step and saves area
  // the counter wraps at TICK_CYC so the tick period never drifts
  always_ff @(posedge clk) begin
    if (rst || tick_cnt_r == 32'(TICK_CYC - 1)) begin
      tick_cnt_r <= 32'h00000000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h00000001;
    end
  end

  // the tick is registered so every port sees it on the same edge
  always_ff @(posedge clk) begin
    tick_r <= !rst && (tick_cnt_r == 32'(TICK_CYC - 1)); // [RULE_23]
  end

  // ---------------------------------------------------------------
  // aggregate configuration
  // ---------------------------------------------------------------
  logic [15:0] sys_prio_r;

  // out of range writes are ignored so the stored value stays legal
  always_ff @(posedge clk) begin
    if (rst) begin
      min_links <= `LAC_MIN_LINKS_RST; // [RULE_02]
    end else if (min_links_we && min_links_wr != 6'h00 && min_links_wr <= `LAC_MIN_LINKS_MAX) begin
      min_links <= min_links_wr; // [RULE_02]
    end
  end

  // zero is not a legal priority, so a write of zero is dropped
  always_ff @(posedge clk) begin
    if (rst || sys_prio_clr) begin
      sys_prio_r <= `LAC_PRIO_RST; // [RULE_06]
    end else if (sys_prio_we && sys_prio_wr != 16'h0000) begin
      sys_prio_r <= sys_prio_wr; // [RULE_06]
    end
  end

  // system id: priority in the upper bits so a larger number ranks lower
  // the key is fixed at build time; it is this aggregate's own number
  always_ff @(posedge clk) begin
    if (rst) begin
      sys_id    <= 64'h0000000000000000;
      admin_key <= 16'h0000;
    end else begin
      sys_id    <= {sys_prio_r, sw_mac}; // [RULE_05] [RULE_06]
      admin_key <= AGG_ID; // [RULE_21]
    end
  end

  // ---------------------------------------------------------------
  // per port control
  // ---------------------------------------------------------------
  logic [NPORT-1:0] selected;

  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi++) begin : g_port
      // per port timers count ticks, so 7 bits cover the 90 tick expiry
      lac_pkg::lac_port_cfg_t c;
      logic        dyn;
      logic        stat;
      logic        lacp_on;
      logic [6:0]  tx_cnt_r;
      logic [6:0]  exp_cnt_r;
      logic        heard_r;
      logic        partner_ok_r;
      logic [6:0]  tx_per;
      logic [6:0]  exp_per;
      logic        key_ok;
      logic        up_ok;
      lac_pkg::lac_state_t st_r;

      // dyn joins by negotiation, stat by configuration alone; lacp_on is any lacp mode
      assign c       = port_cfg[gi];
      assign lacp_on = c.mode == lac_pkg::LAC_MODE_ACTIVE || c.mode == lac_pkg::LAC_MODE_PASSIVE;
      assign dyn     = c.member && (c.mode == lac_pkg::LAC_MODE_ACTIVE || c.mode == lac_pkg::LAC_MODE_PASSIVE);
      assign stat    = c.member && c.mode == lac_pkg::LAC_MODE_STATIC;
      assign tx_per  = c.short_to ? 7'(`LAC_SHORT_TX_S) : 7'(`LAC_LONG_TX_S); // [RULE_08] [RULE_09]
      assign exp_per = c.short_to ? 7'(`LAC_SHORT_EXP_S) : 7'(`LAC_LONG_EXP_S); // [RULE_08] [RULE_09]
      assign key_ok  = pdu_rx_key[gi] == AGG_ID; // [RULE_21]
      assign up_ok   = link_up[gi] && c.admin_up;

      // port priority; clear and zero both fall back to the default
      always_ff @(posedge clk) begin
        if (rst || c.prio_clr || c.prio == 16'h0000) begin
          port_prio[gi] <= `LAC_PRIO_RST; // [RULE_07]
        end else begin
          port_prio[gi] <= c.prio; // [RULE_07]
        end
      end

      // forced activation is refused outside dynamic membership
      always_ff @(posedge clk) begin
        if (rst) begin
          cfg_reject[gi] <= 1'b0;
        end else begin
          cfg_reject[gi] <= c.default_up && !dyn; // [RULE_17]
        end
      end

      // expiry timer: refreshed by each pdu with a matching key
      // a refresh in the cycle of the last tick wins, so a live partner never expires
      always_ff @(posedge clk) begin
        if (rst || !dyn || !link_up[gi]) begin
          exp_cnt_r    <= 7'h00;
          partner_ok_r <= 1'b0;
        end else if (pdu_rx[gi] && key_ok) begin
          exp_cnt_r    <= 7'h00;
          partner_ok_r <= 1'b1;
        end else if (tick_r && partner_ok_r) begin
          if (exp_cnt_r + 7'h01 >= exp_per) begin
            partner_ok_r <= 1'b0; // [RULE_08] [RULE_09]
            exp_cnt_r    <= 7'h00;
          end else begin
            exp_cnt_r <= exp_cnt_r + 7'h01;
          end
        end
      end

      // passive permission: a partner pdu opens it; leaving passive or expiry closes it,
      // so a port switched from active never inherits the right to speak
      always_ff @(posedge clk) begin
        if (rst || !dyn || !link_up[gi] || c.mode != lac_pkg::LAC_MODE_PASSIVE) begin
          heard_r <= 1'b0;
        end else if (pdu_rx[gi] && key_ok) begin
          heard_r <= 1'b1; // [RULE_04]
        end else if (tick_r && partner_ok_r && (exp_cnt_r + 7'h01 >= exp_per)) begin
          heard_r <= 1'b0; // [RULE_04] [RULE_24]
        end
      end

      // expiry event pulse, one cycle
      always_ff @(posedge clk) begin
        if (rst) begin
          expired_evt[gi] <= 1'b0;
        end else begin
          expired_evt[gi] <= dyn && link_up[gi] && !(pdu_rx[gi] && key_ok) && tick_r && partner_ok_r
                             && (exp_cnt_r + 7'h01 >= exp_per); // [RULE_24]
        end
      end

      // periodic transmit; passive waits until the partner spoke first
      // limitation: the first pdu waits for the next tick, up to a second after link up
      always_ff @(posedge clk) begin
        if (rst || !dyn || !link_up[gi]) begin
          tx_cnt_r   <= 7'h00;
          pdu_tx[gi] <= 1'b0; // [RULE_22]
        end else if ((c.mode == lac_pkg::LAC_MODE_ACTIVE || heard_r) && tick_r) begin // [RULE_03] [RULE_04]
          if (tx_cnt_r == 7'h00) begin
            pdu_tx[gi] <= 1'b1;
            tx_cnt_r   <= tx_per - 7'h01;
          end else begin
            pdu_tx[gi] <= 1'b0;
            tx_cnt_r   <= tx_cnt_r - 7'h01;
          end
        end else begin
          pdu_tx[gi] <= 1'b0;
        end
      end

      // mux state: detached, waiting for partner, collecting/distributing
      // waiting covers both a silent partner and a link that is down
      always_ff @(posedge clk) begin
        if (rst) begin
          st_r <= lac_pkg::LAC_ST_DETACHED;
        end else begin
          case (st_r)
            lac_pkg::LAC_ST_DETACHED: begin
              if (c.member && c.mode != lac_pkg::LAC_MODE_NONE) begin
                st_r <= lac_pkg::LAC_ST_WAITING; // [RULE_18]
              end
            end
            lac_pkg::LAC_ST_WAITING: begin
              if (!c.member || c.mode == lac_pkg::LAC_MODE_NONE) begin
                st_r <= lac_pkg::LAC_ST_DETACHED; // [RULE_18]
              end else if (up_ok && (stat || partner_ok_r || c.default_up)) begin
                st_r <= lac_pkg::LAC_ST_COLL_DIST; // [RULE_16] [RULE_22]
              end
            end
            lac_pkg::LAC_ST_COLL_DIST: begin
              if (!c.member || c.mode == lac_pkg::LAC_MODE_NONE) begin
                st_r <= lac_pkg::LAC_ST_DETACHED; // [RULE_18]
              end else if (!up_ok || (dyn && !partner_ok_r && !c.default_up)) begin
                st_r <= lac_pkg::LAC_ST_WAITING; // [RULE_24]
              end
            end
            default: st_r <= lac_pkg::LAC_ST_DETACHED;
          endcase
        end
      end

      assign selected[gi] = st_r == lac_pkg::LAC_ST_COLL_DIST;

      // attach and collect/distribute flags follow the state
      always_ff @(posedge clk) begin
        if (rst) begin
          attached[gi]     <= 1'b0;
          collecting[gi]   <= 1'b0;
          distributing[gi] <= 1'b0;
        end else begin
          attached[gi]     <= st_r != lac_pkg::LAC_ST_DETACHED; // [RULE_18]
          collecting[gi]   <= selected[gi]; // [RULE_19]
          distributing[gi] <= selected[gi]; // [RULE_19]
        end
      end

      // received pdu policy: lacp trap beats any forwarding setting
      // any lacp mode traps, member or not, so no lacp port ever floods a pdu
      always_ff @(posedge clk) begin
        if (rst) begin
          pdu_act[gi] <= lac_pkg::LAC_PDU_DROP;
        end else if (lacp_on) begin
          pdu_act[gi] <= lac_pkg::LAC_PDU_TRAP_CPU; // [RULE_15] [RULE_13]
        end else if (c.fwd_en || (stat && agg_static && agg_fwd_en)) begin // [RULE_14]
          pdu_act[gi] <= rx_vlan_bd[gi] ? lac_pkg::LAC_PDU_FLOOD_BD
                                        : lac_pkg::LAC_PDU_FLOOD_VLAN; // [RULE_11] [RULE_12]
        end else begin
          pdu_act[gi] <= lac_pkg::LAC_PDU_DROP; // [RULE_10]
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // aggregate state and conversation mapping
  // ---------------------------------------------------------------
  logic [6:0] up_cnt;
  logic [6:0] idx_cnt;
  logic [6:0] pick;

  // counts members in collecting/distributing and picks the n-th one
  always_comb begin
    up_cnt  = 7'h00;
    idx_cnt = 7'h00;
    pick    = 7'h00;
    for (int i = 0; i < NPORT; i++) begin
      up_cnt = up_cnt + 7'(selected[i]);
    end
    for (int i = 0; i < NPORT; i++) begin
      if (selected[i]) begin
        if (up_cnt != 7'h00 && idx_cnt == 7'(conv_hash % 16'(up_cnt))) begin
          pick = 7'(i);
        end
        idx_cnt = idx_cnt + 7'h01;
      end
    end
  end

  // the same hash over the same member set always lands on one link
  // limitation: a change of the member set may move a conversation once
  always_ff @(posedge clk) begin
    if (rst) begin
      agg_oper_up <= 1'b0;
      conv_port   <= '0;
      conv_valid  <= 1'b0;
    end else begin
      agg_oper_up <= up_cnt != 7'h00 && up_cnt >= 7'(min_links); // [RULE_01]
      conv_port   <= pick[$clog2(NPORT)-1:0]; // [RULE_20]
      conv_valid  <= up_cnt != 7'h00;
    end
  end

endmodule
`default_nettype wire

// [rtl/lac_cfg.svh]
// Purpose : constants for the link aggregation control block
// Assumes : 10 MHz clock
// Notes   : times in seconds, counts derived from the clock rate
`ifndef LAC_CFG_SVH
`define LAC_CFG_SVH
`define LAC_CLK_HZ          10000000
`define LAC_TICK_CYC        (`LAC_CLK_HZ)
`define LAC_SHORT_TX_S      1
`define LAC_SHORT_EXP_S     3
`define LAC_LONG_TX_S       30
`define LAC_LONG_EXP_S      90
`define LAC_MIN_LINKS_RST   6'h01
`define LAC_MIN_LINKS_MAX   6'h20
`define LAC_PRIO_RST        16'h8000
`endif

// [rtl/lac_pkg.sv]
// Purpose : types for the link aggregation control block
// Assumes : nothing
// Notes   : per-port configuration travels as one packed struct
package lac_pkg;
  typedef enum logic [1:0] {
    LAC_MODE_NONE,
    LAC_MODE_STATIC,
    LAC_MODE_ACTIVE,
    LAC_MODE_PASSIVE
  } lac_mode_t;

  typedef enum logic [1:0] {
    LAC_PDU_DROP,
    LAC_PDU_FLOOD_VLAN,
    LAC_PDU_FLOOD_BD,
    LAC_PDU_TRAP_CPU
  } lac_pdu_act_t;

  typedef struct packed {
    lac_mode_t   mode;
    logic        member;
    logic        short_to;
    logic        fwd_en;
    logic        default_up;
    logic        admin_up;
    logic        prio_clr;
    logic [15:0] prio;
  } lac_port_cfg_t;

  typedef enum {
    LAC_ST_DETACHED,
    LAC_ST_WAITING,
    LAC_ST_COLL_DIST
  } lac_state_t;
endpackage

// [dv/lac_far.sv]
// Purpose : far-side switch answering pdus on each member link
// Assumes : answers DLY cycles after each pdu it hears
// Notes   : mute withholds answers, kick sends one unprompted pdu
`timescale 1ns/1ps
`default_nettype none
module lac_far #(
  parameter int          DLY = 3,
  parameter logic [15:0] KEY = 16'h001E
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  pdu_tx,
  input  wire logic [3:0]  kick,
  input  wire logic [3:0]  mute,
  output logic [3:0]       pdu_rx,
  output logic [15:0]      pdu_rx_key [4]
);
  logic [DLY-1:0][3:0] pipe_r;

  // answers ride a pipe so a refresh never lands in the request's own cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      pipe_r <= '0;
    end else begin
      pipe_r <= {pipe_r[DLY-2:0], (pdu_tx & ~mute) | kick};
    end
  end
  assign pdu_rx = pipe_r[DLY-1];

  // key means nothing between pulses, so show a wrong one there
  always_comb begin
    foreach (pdu_rx_key[i]) pdu_rx_key[i] = pdu_rx[i] ? KEY : ~KEY;
  end
endmodule
`default_nettype wire

// [dv/lac_ctrl_chk.sv]
// Purpose : port and aggregate checks on lac_ctrl
// Assumes : outputs answer one cycle after their cause
// Notes   : per-port checks watch the port the bench exercises
`timescale 1ns/1ps
`default_nettype none
module lac_ctrl_chk #(
  parameter int NPORT = 4
) (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire lac_pkg::lac_port_cfg_t port_cfg [NPORT],
  input wire logic [NPORT-1:0]       link_up,
  input wire logic [NPORT-1:0]       pdu_rx,
  input wire logic [47:0]            sw_mac,
  input wire logic                   agg_oper_up,
  input wire logic [63:0]            sys_id,
  input wire logic [5:0]             min_links,
  input wire logic [15:0]            port_prio [NPORT],
  input wire logic [NPORT-1:0]       pdu_tx,
  input wire logic [NPORT-1:0]       collecting,
  input wire logic [NPORT-1:0]       expired_evt,
  input wire logic [NPORT-1:0]       cfg_reject
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic heard_r;

  // a passive port may speak only after its partner has spoken
  always_ff @(posedge clk) begin
    if (rst || port_cfg[2].mode != lac_pkg::LAC_MODE_PASSIVE) begin
      heard_r <= 1'b0;
    end else if (pdu_rx[2]) begin
      heard_r <= 1'b1;
    end
  end

  sequence passive_hold;
    (port_cfg[2].mode == lac_pkg::LAC_MODE_PASSIVE)[*3];
  endsequence
  sequence static_hold;
    (port_cfg[3].mode == lac_pkg::LAC_MODE_STATIC)[*2];
  endsequence

  min_range_a: assert property (!$past(rst) |-> min_links >= 6'h01 && min_links <= 6'h20)
    else $error("minimum member count out of range");
  sys_mac_a: assert property (!$past(rst) |-> sys_id[47:0] == $past(sw_mac))
    else $error("system id does not carry the switch mac");
  prio_default_a: assert property (!$past(rst) && ($past(port_cfg[0].prio_clr) ||
    $past(port_cfg[0].prio) == 16'h0000) |-> port_prio[0] == 16'h8000)
    else $error("cleared port priority is not the default");
  below_min_a: assert property (($countones(link_up) < min_links)[*6] |-> !agg_oper_up)
    else $error("aggregate up with too few members");
  forced_reject_a: assert property (port_cfg[3].default_up && !(port_cfg[3].member &&
    port_cfg[3].mode inside {lac_pkg::LAC_MODE_ACTIVE, lac_pkg::LAC_MODE_PASSIVE}) |=> cfg_reject[3])
    else $error("forced activation accepted on a non dynamic port");
  passive_quiet_a: assert property (passive_hold ##0 pdu_tx[2] |-> heard_r)
    else $error("passive port opened the exchange");
  static_silent_a: assert property (static_hold |-> !pdu_tx[3])
    else $error("static member sent a pdu");
  expire_drop_a: assert property (expired_evt[0] |-> ##[1:3] !collecting[0])
    else $error("expired port still collecting");
endmodule
bind lac_ctrl lac_ctrl_chk #(.NPORT(NPORT)) u_lac_ctrl_chk (.clk, .rst, .port_cfg, .link_up, .pdu_rx, .sw_mac,
  .agg_oper_up, .sys_id, .min_links, .port_prio, .pdu_tx, .collecting, .expired_evt, .cfg_reject);
`default_nettype wire

// [dv/test_lac_ctrl.sv]
// Purpose : self-checking bench for lac_ctrl
// Assumes : the one-second tick is shortened to TK cycles
// Notes   : inputs change 10 ns after each rising edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
`define WT(c, m) begin k = 0; while (!(c) && k < (m)) begin step(1); k++; end end
module test_lac_ctrl;
  localparam int          TK = 10;
  logic                   clk = 1'b0;
  logic                   rst = 1'b1;
  lac_pkg::lac_port_cfg_t port_cfg [4];
  logic [3:0]             link_up = 4'h0, rx_vlan_bd = 4'h0, kick = 4'h0, mute = 4'h0, pdu_rx, pdu_tx;
  logic [3:0]             attached, collecting, distributing, expired_evt, cfg_reject;
  logic                   agg_static = 1'b0, agg_fwd_en = 1'b0, min_links_we = 1'b0, sys_prio_we = 1'b0;
  logic                   sys_prio_clr = 1'b0, agg_oper_up, conv_valid;
  logic [5:0]             min_links_wr = 6'h01, min_links;
  logic [15:0]            sys_prio_wr = 16'h0001, conv_hash = 16'h0000, admin_key, pdu_rx_key [4], port_prio [4];
  logic [63:0]            sys_id;
  logic [47:0]            sw_mac = 48'h0A1B2C3D4E5F;
  logic [1:0]             conv_port;
  lac_pkg::lac_pdu_act_t  pdu_act [4];
  int                     n_fail = 0, comparisons = 0, cyc = 0, k, n;
  logic [5:0]             mv [4] = '{6'h00, 6'h21, 6'h20, 6'h04};
  logic [5:0]             me [4] = '{6'h01, 6'h01, 6'h20, 6'h04};
  logic [15:0]            sv [4] = '{16'h0001, 16'h0000, 16'h0000, 16'hFFFF};
  logic [15:0]            se [4] = '{16'h0001, 16'h0001, 16'h8000, 16'hFFFF};

  lac_ctrl #(.NPORT(4), .TICK_CYC(TK)) u_lac_ctrl (.clk, .rst, .port_cfg, .link_up, .pdu_rx, .pdu_rx_key,
    .rx_vlan_bd, .agg_static, .agg_fwd_en, .min_links_wr, .min_links_we, .sys_prio_wr, .sys_prio_we,
    .sys_prio_clr, .sw_mac, .conv_hash, .agg_oper_up, .sys_id, .admin_key, .min_links, .port_prio, .pdu_tx,
    .pdu_act, .attached, .collecting, .distributing, .expired_evt, .cfg_reject, .conv_port, .conv_valid);
  lac_far u_lac_far (.clk, .rst, .pdu_tx, .kick, .mute, .pdu_rx, .pdu_rx_key);

  // clock, and a ceiling well past the 90 s expiry wait
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #10;
  endtask

  task automatic conclude();
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // f holds {port forwarding, bridge-domain vlan, static aggregate with forwarding}
  task automatic act_chk(input lac_pkg::lac_mode_t m, input logic [2:0] f, input lac_pkg::lac_pdu_act_t e);
    port_cfg[3].mode = m;
    {port_cfg[3].fwd_en, rx_vlan_bd[3], agg_static} = f;
    agg_fwd_en = f[0];
    port_cfg[3].member = f[0];
    kick[3] = 1'b1;
    step(1);
    kick[3] = 1'b0;
    step(5);
    `CHK("pdu_act", e, pdu_act[3])
  endtask

  initial begin
    foreach (port_cfg[i]) port_cfg[i] = '{lac_pkg::LAC_MODE_ACTIVE, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 16'h0000};
    step(10);
    rst = 1'b0;
    step(2);
    `CHK("sys_id prio", 16'h8000, sys_id[63:48])
    `CHK("sys_id mac", sw_mac, sys_id[47:0])
    `CHK("admin_key", 16'h001E, admin_key)
    `CHK("min_links", 6'h01, min_links)
    foreach (mv[i]) begin
      min_links_wr = mv[i];
      min_links_we = 1'b1;
      step(1);
      min_links_we = 1'b0;
      step(1);
      `CHK("min_links", me[i], min_links)
    end
    foreach (sv[i]) begin
      sys_prio_wr = sv[i];
      sys_prio_we = (i != 2);
      sys_prio_clr = (i == 2);
      step(1);
      {sys_prio_we, sys_prio_clr} = 2'b00;
      step(1);
      `CHK("sys_prio", se[i], sys_id[63:48])
    end
    `CHK("port_prio", 16'h8000, port_prio[0])
    port_cfg[0].prio = 16'h000C;
    step(2);
    `CHK("port_prio", 16'h000C, port_prio[0])
    port_cfg[0].prio_clr = 1'b1;
    step(2);
    `CHK("port_prio", 16'h8000, port_prio[0])
    port_cfg[0].prio_clr = 1'b0;
    link_up = 4'hF;
    `WT(collecting == 4'hF, 100)
    `CHK("collecting", 4'hF, collecting)
    `CHK("attached", 4'hF, attached)
    `CHK("distributing", 4'hF, distributing)
    `CHK("conv_valid", 1'b1, conv_valid)
    `CHK("oper_up", 1'b1, agg_oper_up)
    for (int h = 0; h < 8; h++) begin
      conv_hash = 16'(h);
      step(2);
      `CHK("conv_port", 2'(h % 4), conv_port)
    end
    link_up[3] = 1'b0;
    step(8);
    `CHK("oper_up", 1'b0, agg_oper_up)
    min_links_wr = 6'h03;
    min_links_we = 1'b1;
    step(1);
    min_links_we = 1'b0;
    conv_hash = 16'h0005;
    step(4);
    `CHK("oper_up", 1'b1, agg_oper_up)
    `CHK("conv_port", 2'h2, conv_port)
    n = 0;
    repeat (10 * TK) begin
      step(1);
      n += pdu_tx[0];
    end
    `CHK("short tx", 1'b1, n inside {[9:11]})
    mute[0] = 1'b1;
    `WT(expired_evt[0], 60)
    `CHK("short expiry", 1'b1, k inside {[18:32]})
    step(3);
    `CHK("collecting", 1'b0, collecting[0])
    port_cfg[1].short_to = 1'b0;
    mute[2:1] = 2'b11;
    n = 0;
    k = 0;
    while (!expired_evt[1] && k < 1000) begin
      step(1);
      k++;
      n += pdu_tx[1];
    end
    `CHK("long expiry", 1'b1, k inside {[880:910]})
    `CHK("long tx", 1'b1, n inside {[2:4]})
    port_cfg[2].mode = lac_pkg::LAC_MODE_PASSIVE;
    n = 0;
    repeat (5 * TK) begin
      step(1);
      n += pdu_tx[2];
    end
    `CHK("passive quiet", 0, n)
    kick[2] = 1'b1;
    step(1);
    kick[2] = 1'b0;
    `WT(pdu_tx[2], 3 * TK)
    `CHK("passive reply", 1'b1, pdu_tx[2])
    act_chk(lac_pkg::LAC_MODE_NONE, 3'b000, lac_pkg::LAC_PDU_DROP);
    act_chk(lac_pkg::LAC_MODE_NONE, 3'b100, lac_pkg::LAC_PDU_FLOOD_VLAN);
    act_chk(lac_pkg::LAC_MODE_NONE, 3'b110, lac_pkg::LAC_PDU_FLOOD_BD);
    act_chk(lac_pkg::LAC_MODE_STATIC, 3'b001, lac_pkg::LAC_PDU_FLOOD_VLAN);
    act_chk(lac_pkg::LAC_MODE_ACTIVE, 3'b100, lac_pkg::LAC_PDU_TRAP_CPU);
    act_chk(lac_pkg::LAC_MODE_PASSIVE, 3'b100, lac_pkg::LAC_PDU_TRAP_CPU);
    port_cfg[3] = '{lac_pkg::LAC_MODE_STATIC, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 16'h0000};
    {agg_static, agg_fwd_en} = 2'b00;
    step(3);
    `CHK("reject", 1'b1, cfg_reject[3])
    port_cfg[3].mode = lac_pkg::LAC_MODE_ACTIVE;
    mute[3] = 1'b1;
    link_up[3] = 1'b1;
    `WT(collecting[3], 40)
    `CHK("forced up", 1'b1, collecting[3])
    `CHK("reject", 1'b0, cfg_reject[3])
    port_cfg[3].member = 1'b0;
    step(5);
    `CHK("detach", 1'b0, attached[3])
    conclude();
  end
endmodule
`default_nettype wire
